/* verilog/sar_seq_pkg.sv */
// shared constants and carriers for the conversion sequencer
package sar_seq_pkg;
  localparam int RES_BITS = 16;
  localparam int STEP_W = 5;
  localparam logic [4:0] LAST_STEP = 5'h10;     // step of the lsb decision
  localparam logic [4:0] FIRST_STEP = 5'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int GATED_HALF_NS = 80;            // gated clock half period
  localparam int GATED_HALF_CYC = (GATED_HALF_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_CNT = 4'(GATED_HALF_CYC - 1);
  localparam int DATA_LEAD_NS = 20;             // data valid before flag fall
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int FLAG_DELAY_NS = 40;            // flag fall after last step
  localparam int FLAG_DELAY_CYC = FLAG_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [2:0] FLAG_CNT = 3'(FLAG_DELAY_CYC - 1);
  localparam logic [15:0] SAR_INIT = 16'h7fff;  // msb trial low, rest high

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_TAIL = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic busy;
    logic clk_out;
    logic [RES_BITS-1:0] data;
  } result_s;
endpackage

/* verilog/pin_sync.sv */
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // ---------------------------------------------------------------
  // capture chain; first stage feeds only the second
  // ---------------------------------------------------------------
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule

/* verilog/sar_conversion_sequencer.sv */
// successive-approximation conversion sequencer with gated clock
`timescale 1ns/1ns
// What this block does
// R01 - each trigger yields a 16-bit conversion of the sampled input, or fewer bits when the shortening input ends it early.
// R02 - the approximation register drives both result pins and dac inputs.
// R03 - one bit is compared per step, msb first and lsb last.
// R04 - each bit is kept or set by the comparator at the end of its step.
// R05 - the busy flag rises when a trigger is received.
// R06 - a raised flag ungates the clock for exactly 17 cycles in a full, unshortened conversion.
// R07 - register, status and gating are initialised on the trigger's fall.
// R08 - step one clears the msb and sets the rest; later steps decide and try.
// R09 - decide and trial repeat until the lsb is decided on the last step.
// R10 - after the last decision the busy flag falls and the result is valid.
// R11 - a falling flag regates the clock and holds the clock output low.
// R12 - the clock output stays low between conversions.
// R13 - each result bit changes on the clock edge that completes its decision.
// R14 - the result stands at least 20 ns before the flag falls.
// R15 - result pins are presented inverted, as plain or offset code.
// R16 - a shortening input tied to a bit output ends the cycle 40 ns later.
// R17 - a step counter on gated clock rises sequences the bits to terminal.
module sar_conversion_sequencer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic convert_i,
  input wire logic comparator_i,
  input wire logic short_cycle_i,
  output logic busy_o,
  output logic gated_clk_o,
  output logic [15:0] result_o,
  output logic [15:0] dac_bits_o
);
  localparam int N = sar_seq_pkg::RES_BITS;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins;
  pin_sync #(.W(3)) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({short_cycle_i, comparator_i, convert_i}),
    .sync_o(pins)
  );

  logic conv_s;
  logic comp_s;
  logic short_s;
  logic conv_d;
  logic next_conv_d;
  logic conv_fall;
  always_comb begin
    conv_s = pins[0];
    comp_s = pins[1];
    short_s = pins[2];
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  sar_seq_pkg::seq_state_e state;
  sar_seq_pkg::seq_state_e next_state;
  logic [N-1:0] sar;
  logic [N-1:0] next_sar;
  logic [sar_seq_pkg::STEP_W-1:0] step;
  logic [sar_seq_pkg::STEP_W-1:0] next_step;
  logic [3:0] half;
  logic [3:0] next_half;
  logic [2:0] tail;
  logic [2:0] next_tail;
  logic clk_q;
  logic next_clk_q;
  logic busy;
  logic next_busy;
  logic armed;
  logic next_armed;
  sar_seq_pkg::result_s out_q;
  sar_seq_pkg::result_s next_out;

  // bit index under trial at a given step, msb is index n-1
  function automatic logic [N-1:0] bit_mask(
    input logic [sar_seq_pkg::STEP_W-1:0] s
  );
    logic [N-1:0] m;
    m = '0;
    if (s < sar_seq_pkg::STEP_W'(N))
      m[N-1-int'(s)] = 1'b1;
    bit_mask = m;
  endfunction

  // edge of the trigger; conversion starts when it is released
  always_comb begin
    next_conv_d = conv_s;
    conv_fall = conv_d & ~conv_s;
  end

  // ---------------------------------------------------------------
  // gated clock rise detect
  // ---------------------------------------------------------------
  // a rise is due when the low half period has run out while running
  logic gclk_rise;
  always_comb begin
    gclk_rise = (state == sar_seq_pkg::ST_RUN) && (half == 4'h0) && !clk_q;
  end

  // ---------------------------------------------------------------
  // short cycle watch
  // ---------------------------------------------------------------
  // the strapped bit pin comes back through the host and through the
  // pin synchroniser, so it cannot be seen at the rise that sets it;
  // it is judged a fixed time after each rise instead, which lands
  // the flag fall 40 ns after the step that ends the conversion
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic short_hit;
  always_comb begin
    next_settle = settle;
    short_hit = 1'b0;
    if (gclk_rise) begin
      next_settle = sar_seq_pkg::FLAG_CNT;                  // R16
    end else if (settle != 3'h0) begin
      next_settle = settle - 3'h1;
    end
    // only the state machine acts on the hit, and only while running
    if (state == sar_seq_pkg::ST_RUN && settle == 3'h1 && short_s)
      short_hit = 1'b1;                                     // R16
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle <= 3'h0;
    end else begin
      settle <= next_settle;
    end
  end

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // the gated clock is produced here by dividing the system clock; a
  // rising edge ends each step, so 17 rises cover init plus 16 decisions
  always_comb begin
    logic rise;
    logic last;
    logic [N-1:0] cur;
    logic [N-1:0] nxt;
    rise = 1'b0;
    last = 1'b0;
    cur = '0;
    nxt = '0;
    next_state = state;
    next_sar = sar;
    next_step = step;
    next_half = half;
    next_tail = tail;
    next_clk_q = clk_q;
    next_busy = busy;
    next_armed = armed;
    if (conv_s && !busy)
      next_armed = 1'b1;
    case (state)
      sar_seq_pkg::ST_IDLE: begin
        next_clk_q = 1'b0;                                  // R12
        if (conv_s)
          next_busy = 1'b1;                                 // R05
        if (conv_fall || (armed && !conv_s)) begin
          // initialisation on the trailing edge of the trigger
          next_sar = '1;                                    // R07
          next_step = sar_seq_pkg::FIRST_STEP;              // R07
          next_half = sar_seq_pkg::HALF_CNT;
          next_clk_q = 1'b0;                                // R07
          next_busy = 1'b1;                                 // R05
          next_armed = 1'b0;
          next_state = sar_seq_pkg::ST_RUN;                 // R06
        end
      end
      sar_seq_pkg::ST_RUN: begin
        if (half != 4'h0) begin
          next_half = half - 4'h1;
        end else begin
          next_half = sar_seq_pkg::HALF_CNT;
          next_clk_q = ~clk_q;                              // R06
          rise = ~clk_q;
        end
        if (rise) begin
          cur = bit_mask(step - sar_seq_pkg::STEP_W'(1));
          nxt = bit_mask(step);
          if (step == sar_seq_pkg::FIRST_STEP) begin
            next_sar = sar_seq_pkg::SAR_INIT;               // R08
          end else begin
            // keep the decided bit when the input exceeds the dac
            next_sar = comp_s ? sar : (sar | cur);          // R04
            next_sar = next_sar & ~nxt;                     // R03
          end
          // a tied shortening pin reads the bit output now tried high
          last = (step == sar_seq_pkg::LAST_STEP);          // R09
          next_step = step + sar_seq_pkg::STEP_W'(1);       // R17
          if (last) begin
            next_tail = sar_seq_pkg::FLAG_CNT;
            next_state = sar_seq_pkg::ST_TAIL;
          end
        end else if (short_hit) begin
          // strapped pin settled high: stop at the bit just decided
          next_tail = 3'h0;                                 // R16
          next_state = sar_seq_pkg::ST_TAIL;                // R16
        end
      end
      sar_seq_pkg::ST_TAIL: begin
        // result already stands; flag falls 40 ns after the last rise
        if (clk_q && half != 4'h0)
          next_half = half - 4'h1;
        else
          next_clk_q = 1'b0;
        if (tail != 3'h0) begin
          next_tail = tail - 3'h1;                          // R14
        end else begin
          next_busy = 1'b0;                                 // R10
          next_clk_q = 1'b0;                                // R11
          next_state = sar_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sar_seq_pkg::ST_IDLE;
        next_busy = 1'b0;
        next_clk_q = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= sar_seq_pkg::ST_IDLE;
      sar <= '1;
      step <= sar_seq_pkg::FIRST_STEP;
      half <= 4'h0;
      tail <= 3'h0;
      clk_q <= 1'b0;
      busy <= 1'b0;
      armed <= 1'b0;
      conv_d <= 1'b0;
    end else begin
      state <= next_state;
      sar <= next_sar;
      step <= next_step;
      half <= next_half;
      tail <= next_tail;
      clk_q <= next_clk_q;
      busy <= next_busy;
      armed <= next_armed;
      conv_d <= next_conv_d;
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // per-bit fan-out of the approximation register; the dac side takes
  // true bits and the pins the inverted ones, from one source
  logic [N-1:0] dac_q;
  logic [N-1:0] next_dac;
  logic [N-1:0] next_pin;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_bits
      assign next_dac[gi] = next_sar[gi];                   // R02
      assign next_pin[gi] = ~next_sar[gi];                  // R15
    end
  endgenerate

  // pins are negative-true; the same register drives dac and pins, so
  // they change together with the clock rise that settles the bit
  always_comb begin
    next_out.busy = next_busy;
    next_out.clk_out = next_clk_q;                          // R11
    next_out.data = next_pin;                               // R15
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
      dac_q <= '1;
    end else begin
      out_q <= next_out;                                    // R13
      dac_q <= next_dac;
    end
  end

  // parallel result, flag and clock pins
  assign busy_o = out_q.busy;
  assign gated_clk_o = out_q.clk_out;
  assign result_o = out_q.data;                             // R01
  assign dac_bits_o = dac_q;
endmodule

/* tb/seq_properties.sv */
// port assertions for the conversion sequencer
`timescale 1ns/1ns
module seq_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic convert_i,
  input wire logic short_cycle_i,
  input wire logic busy_o,
  input wire logic gated_clk_o,
  input wire logic [15:0] result_o,
  input wire logic [15:0] dac_bits_o
);
  // ----
  // timing relations, all in the system clock domain
  // ----
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_idle; !busy_o |-> !gated_clk_o; endproperty
  a_idle: assert property (p_idle) else $error("clock out idle");
  property p_low; $fell(gated_clk_o) |-> !gated_clk_o [*8]; endproperty
  a_low: assert property (p_low) else $error("low phase");
  property p_high; $rose(gated_clk_o) |-> gated_clk_o [*4]; endproperty
  a_high: assert property (p_high) else $error("high phase");
  property p_run; $rose(gated_clk_o) |-> busy_o; endproperty
  a_run: assert property (p_run) else $error("clock sans flag");
  property p_go; $rose(convert_i) |-> ##[2:5] busy_o; endproperty
  a_go: assert property (p_go) else $error("flag late");
  property p_inv; result_o == ~dac_bits_o; endproperty
  a_inv: assert property (p_inv) else $error("pins not inverted");
  property p_edge;
    busy_o && $changed(result_o) |-> $rose(gated_clk_o) || result_o == 16'h0000;
  endproperty
  a_edge: assert property (p_edge) else $error("data off edge");
  property p_lead;
    $fell(busy_o) |-> $stable(result_o) && $past(result_o) == $past(result_o, 2);
  endproperty
  a_lead: assert property (p_lead) else $error("data lead");
  property p_end;
    $fell(busy_o) |-> $past(gated_clk_o, 4) && !$past(gated_clk_o, 5);
  endproperty
  a_end: assert property (p_end) else $error("flag fall");
  c_full: cover property ($fell(busy_o) && !short_cycle_i);
  c_short: cover property ($fell(busy_o) && short_cycle_i);
  c_rise: cover property ($rose(gated_clk_o));
endmodule
bind sar_conversion_sequencer seq_props i_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .convert_i(convert_i),
  .short_cycle_i(short_cycle_i), .busy_o(busy_o), .gated_clk_o(gated_clk_o),
  .result_o(result_o), .dac_bits_o(dac_bits_o));

/* tb/host_model.sv */
// host side: trigger, analog comparator, capture on flag fall
`timescale 1ns/1ns
module host_model (
  input wire logic clock_i,
  input wire logic busy_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] dac_i,
  input wire logic [15:0] result_i,
  output logic convert_o,
  output logic comparator_o,
  output logic [15:0] captured_o
);
  initial convert_o = 1'b0;
  initial comparator_o = 1'b0;
  initial captured_o = 16'h0000;
  // level is in output code units; dac is complement coded
  always @(negedge clock_i) comparator_o <= ((~dac_i) <= level_i);
  // take the data on the falling flag edge
  always @(negedge busy_i) captured_o = result_i;
  // trigger held three cycles so the synchroniser sees it
  task automatic pulse();
    @(negedge clock_i);
    convert_o = 1'b1;
    repeat (3) @(negedge clock_i);
    convert_o = 1'b0;
  endtask
endmodule

/* tb/sar_conversion_sequencer_bench.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) check(n, e, g)
module sar_conversion_sequencer_bench;
  logic clock_i, rst_n_i, short_cycle_i, short_en, conv, comp, busy, gclk;
  logic [15:0] result, dac, level, captured;
  int miscompares, total_checks, rises;
  sar_conversion_sequencer i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .convert_i(conv), .comparator_i(comp), .short_cycle_i(short_cycle_i),
    .busy_o(busy), .gated_clk_o(gclk), .result_o(result), .dac_bits_o(dac));
  host_model i_host (.clock_i(clock_i), .busy_i(busy), .level_i(level),
    .dac_i(dac), .result_i(result), .convert_o(conv), .comparator_o(comp),
    .captured_o(captured));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // shortening pin strapped to inverted bit 11 for ten bits
  always @(negedge clock_i) short_cycle_i <= short_en & result[5];
  always @(posedge gclk) rises++;
  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one conversion; bounded wait so a stuck flag cannot hang
  task automatic run(logic [15:0] t, logic s);
    int n;
    level = t;
    short_en = s;
    rises = 0;
    i_host.pulse();
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("[FAIL] busy end exp 0 got 1");
    end
  endtask
  task automatic t_full();
    logic [15:0] codes [4] = '{16'h0000, 16'hffff, 16'h677a, 16'h8001};
    foreach (codes[i]) begin
      run(codes[i], 1'b0);
      `CHK("result", codes[i], captured);
      `CHK("rises", 16'h0011, 16'(rises));
    end
  endtask
  task automatic t_idle();
    rises = 0;
    repeat (100) @(negedge clock_i);
    `CHK("idle rises", 16'h0000, 16'(rises));
    `CHK("idle data", 16'h8001, result);
  endtask
  task automatic t_short();
    run(16'ha5c3, 1'b1);
    `CHK("short msbs", 16'ha5c3 >> 6, captured >> 6);
    `CHK("short end", 16'h000b, 16'(rises));
    short_en = 1'b0;
  endtask
  task automatic t_reset();
    level = 16'h1234;
    i_host.pulse();
    repeat (60) @(negedge clock_i);
    rst_n_i = 1'b0;
    #1;
    `CHK("rst busy", 16'h0000, {14'h0, busy, gclk});
    `CHK("rst dac", 16'hffff, dac);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    run(16'h1234, 1'b0);
    `CHK("after rst", 16'h1234, captured);
  endtask
  initial begin
    rst_n_i = 1'b0;
    short_en = 1'b0;
    short_cycle_i = 1'b0;
    level = 16'h0000;
    miscompares = 0;
    total_checks = 0;
    rises = 0;
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_full();
    t_idle();
    t_short();
    t_reset();
    report_and_stop();
  end
  // seven conversions of about 300 cycles each fit well inside this
  initial begin
    #60000;
    miscompares++;
    report_and_stop();
  end
endmodule
